/* pmw_params.svh */
// Purpose: Constants for the bus master handshake and wake event block
// Assumes: 40 MHz system clock, figures below are in nanoseconds, cycles or bits
// Notes:   Definitions only, included by bare name
//
// What this block does
// - Drive bus request low whenever a master transfer needs the bus.
// - Wake event output is active low open drain, pulls low or releases.
// - Pull the wake event output low when an internal power event occurs.
// - Wake enable bit 18 of the wake control register selects network wake mode.
// - In network wake mode a received wake frame asserts the wake event output.
// - Protocol select bit 17 picks the first convention when set, second when clear.
// - Address and data share the multiplexed lines, address phase then data phases.
// - Command in address phase, byte enables in data phases, driven by initiator.
// - The bus master holds frame active until its final data phase, then releases it.
// - The master asserts initiator ready when ready for the current data transfer.
// - All bus signals are sampled and driven on the rising clock edge.
// - During reset all bus outputs except req_n, which is held high, float and open drain outputs are released.
`ifndef PMW_PARAMS_SVH
`define PMW_PARAMS_SVH

// ==========================================================
// Timing
`define PMW_CLK_PERIOD_NS   25
`define PMW_WAKE_PULSE_NS   1000
`define PMW_WAKE_PULSE_CYC  ((`PMW_WAKE_PULSE_NS + `PMW_CLK_PERIOD_NS - 1) / `PMW_CLK_PERIOD_NS)

// ==========================================================
// Wake control register field positions
`define PMW_WAKE_EN_BIT     18
`define PMW_WAKE_PROTO_BIT  17

// ==========================================================
// Bus encodings and reset values
`define PMW_CMD_WRITE_BIT   0
`define PMW_CMD_CFG_READ    4'ha
`define PMW_CMD_CFG_WRITE   4'hb
`define PMW_AD_RST          32'h0000_0000
`define PMW_CBE_RST         4'hf

`endif

/* pmw_pkg.sv */
// Purpose: Types shared by the bus master handshake block
// Assumes: Nothing beyond SystemVerilog
// Notes:   Used by scoped name only
package pmw_pkg;

    // ==========================================================
    // Master sequencer states
    typedef enum logic [2:0] {
        st_idle,
        st_req,
        st_addr,
        st_data,
        st_turn
    } pmw_state_e;

endpackage

/* pmw_wake_event.sv */
// Purpose: Open drain power management event output with network wake mode
// Assumes: Event inputs are synchronous single-cycle or level strobes
// Notes:   Pulse convention when protocol select is set, level otherwise
`timescale 1ns/1ps
`include "pmw_params.svh"

module pmw_wake_event #(
    parameter int PULSE_CYC = `PMW_WAKE_PULSE_CYC
) (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic wake_lan_enable,
    input  wire logic wake_protocol_select,
    input  wire logic wake_frame,
    input  wire logic pm_event,
    input  wire logic pme_clear,
    output logic      pme_n_o,
    output logic      pme_n_oe
);

    localparam int CW = $clog2(PULSE_CYC + 1);

    logic          oe_q,    oe_d;
    logic          pulse_q, pulse_d;
    logic [CW-1:0] cnt_q,   cnt_d;
    logic          fire;

    // Event sources: internal event, or wake frame in wake mode
    assign fire = pm_event || (wake_lan_enable && wake_frame);

    // Next state of the event driver
    always_comb begin
        oe_d    = oe_q;
        pulse_d = pulse_q;
        cnt_d   = cnt_q;
        if (oe_q && pulse_q) begin
            cnt_d = cnt_q - CW'(1);
            if (cnt_q == CW'(1)) begin
                oe_d = 1'b0;
            end
        end else if (oe_q && pme_clear) begin
            oe_d = 1'b0; // Level held until software clears
        end
        if (fire) begin // Set wins over clear
            oe_d    = 1'b1;
            pulse_d = wake_protocol_select;
            cnt_d   = CW'(PULSE_CYC);
        end
    end

    // Registers; released after reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            oe_q    <= 1'b0;
            pulse_q <= 1'b0;
            cnt_q   <= '0;
        end else begin
            oe_q    <= oe_d;
            pulse_q <= pulse_d;
            cnt_q   <= cnt_d;
        end
    end

    // Open drain: only ever drives low
    assign pme_n_oe = oe_q;
    assign pme_n_o  = 1'b0;

    // ==========================================================
    // Assertions
    a_pme_on_event: assert property (@(posedge sys_clk) disable iff (!nrst)
        pm_event |=> pme_n_oe) else $error("event did not pull wake line low");
    a_wake_frame_fires: assert property (@(posedge sys_clk) disable iff (!nrst)
        (wake_lan_enable && wake_frame) |=> pme_n_oe) else $error("wake frame ignored");
    a_wake_mode_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
        (!pme_n_oe && !pm_event && !(wake_lan_enable && wake_frame)) |=> !pme_n_oe)
        else $error("wake line asserted outside wake mode");
    a_pulse_length: assert property (@(posedge sys_clk) disable iff (!nrst)
        (fire && wake_protocol_select) |=> pme_n_oe[*8]) else $error("pulse too short");
    a_level_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
        (pme_n_oe && !pulse_q && !pme_clear) |=> pme_n_oe) else $error("level dropped early");
    c_pulse_mode: cover property (@(posedge sys_clk) disable iff (!nrst)
        fire && wake_protocol_select);
endmodule

/* pmw_bus_master.sv */
// Purpose: Bus master request/grant, address/data sequencing and wake output
// Assumes: Inputs synchronous to sys_clk; target ready sampled as an input
// Notes:   One transaction per request; target stop and parity not handled
`timescale 1ns/1ps
`include "pmw_params.svh"

module pmw_bus_master #(
    parameter int LEN_W     = 5,
    parameter int PULSE_CYC = `PMW_WAKE_PULSE_CYC
) (
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    // Arbitration
    output logic                  req_n,
    input  wire logic             gnt_n,
    input  wire logic             idsel,
    // Multiplexed address/data
    input  wire logic [31:0]      ad_i,
    output logic      [31:0]      ad_o,
    output logic                  ad_oe,
    // Command / byte enables
    input  wire logic [3:0]       cbe_n_i,
    output logic      [3:0]       cbe_n_o,
    output logic                  cbe_n_oe,
    // Frame and ready strobes
    input  wire logic             frame_n_i,
    output logic                  frame_n_o,
    output logic                  frame_n_oe,
    input  wire logic             irdy_n_i,
    output logic                  irdy_n_o,
    output logic                  irdy_n_oe,
    input  wire logic             trdy_n,
    // Power management event
    output logic                  pme_n_o,
    output logic                  pme_n_oe,
    // User transfer port
    input  wire logic             xfer_start,
    input  wire logic [3:0]       xfer_cmd,
    input  wire logic [31:0]      xfer_addr,
    input  wire logic [LEN_W-1:0] xfer_len,
    input  wire logic [3:0]       xfer_be_n,
    input  wire logic [31:0]      wr_data,
    output logic                  wr_take,
    output logic      [31:0]      rd_data,
    output logic                  rd_valid,
    output logic                  xfer_busy,
    output logic                  xfer_done,
    output logic                  cfg_hit,
    // Wake control
    input  wire logic             wake_lan_enable,
    input  wire logic             wake_protocol_select,
    input  wire logic             wake_frame,
    input  wire logic             pm_event,
    input  wire logic             pme_clear
);

    pmw_pkg::pmw_state_e st_q, st_d;

    logic [3:0]       cmd_q,      cmd_d;
    logic [31:0]      addr_q,     addr_d;
    logic [LEN_W-1:0] rem_q,      rem_d;
    logic [3:0]       be_q,       be_d;
    logic             req_n_q,    req_n_d;
    logic [31:0]      ad_q,       ad_d;
    logic             ad_oe_q,    ad_oe_d;
    logic [3:0]       cbe_q,      cbe_d;
    logic             cbe_oe_q,   cbe_oe_d;
    logic             frame_q,    frame_d;
    logic             frame_oe_q, frame_oe_d;
    logic             irdy_q,     irdy_d;
    logic             irdy_oe_q,  irdy_oe_d;
    logic             take_q,     take_d;
    logic [31:0]      rdat_q,     rdat_d;
    logic             rval_q,     rval_d;
    logic             busy_q,     busy_d;
    logic             done_q,     done_d;
    logic             cfg_q,      cfg_d;
    logic             fprev_q,    fprev_d;
    logic             is_write;
    logic             bus_idle;

    // ==========================================================
    // Decode helpers
    assign is_write = cmd_q[`PMW_CMD_WRITE_BIT];
    assign bus_idle = frame_n_i && irdy_n_i;

    // ==========================================================
    // Master sequencer next state
    always_comb begin
        st_d       = st_q;
        cmd_d      = cmd_q;
        addr_d     = addr_q;
        rem_d      = rem_q;
        be_d       = be_q;
        req_n_d    = req_n_q;
        ad_d       = ad_q;
        ad_oe_d    = ad_oe_q;
        cbe_d      = cbe_q;
        cbe_oe_d   = cbe_oe_q;
        frame_d    = frame_q;
        frame_oe_d = frame_oe_q;
        irdy_d     = irdy_q;
        irdy_oe_d  = irdy_oe_q;
        take_d     = 1'b0;
        rdat_d     = rdat_q;
        rval_d     = 1'b0;
        busy_d     = busy_q;
        done_d     = 1'b0;
        case (st_q)
            pmw_pkg::st_idle: begin
                if (xfer_start && (xfer_len != '0)) begin
                    cmd_d   = xfer_cmd;
                    addr_d  = xfer_addr;
                    rem_d   = xfer_len;
                    be_d    = xfer_be_n;
                    req_n_d = 1'b0;
                    busy_d  = 1'b1;
                    st_d    = pmw_pkg::st_req;
                end
            end
            pmw_pkg::st_req: begin
                // Take the bus only on grant with no tenure in progress
                if (!gnt_n && bus_idle) begin
                    req_n_d    = 1'b1;
                    frame_d    = 1'b0;
                    frame_oe_d = 1'b1;
                    ad_d       = addr_q;
                    ad_oe_d    = 1'b1;
                    cbe_d      = cmd_q;
                    cbe_oe_d   = 1'b1;
                    irdy_d     = 1'b1;
                    irdy_oe_d  = 1'b1;
                    st_d       = pmw_pkg::st_addr;
                end
            end
            pmw_pkg::st_addr: begin
                irdy_d = 1'b0;
                cbe_d  = be_q;
                if (is_write) begin
                    ad_d   = wr_data;
                    take_d = 1'b1;
                end else begin
                    ad_oe_d = 1'b0; // Turnaround for target read data
                end
                if (rem_q == LEN_W'(1)) begin
                    frame_d = 1'b1; // Last phase: frame off, irdy on
                end
                st_d = pmw_pkg::st_data;
            end
            pmw_pkg::st_data: begin
                if (!trdy_n) begin
                    if (!is_write) begin
                        rdat_d = ad_i;
                        rval_d = 1'b1;
                    end
                    rem_d = rem_q - LEN_W'(1);
                    if (rem_q == LEN_W'(1)) begin
                        irdy_d   = 1'b1;
                        ad_oe_d  = 1'b0;
                        cbe_oe_d = 1'b0;
                        done_d   = 1'b1;
                        st_d     = pmw_pkg::st_turn;
                    end else begin
                        if (is_write) begin
                            ad_d   = wr_data;
                            take_d = 1'b1;
                        end
                        if (rem_q == LEN_W'(2)) begin
                            frame_d = 1'b1;
                        end
                    end
                end
            end
            pmw_pkg::st_turn: begin
                // Irdy driven high one cycle, frame high since the last data phase; both now released
                frame_oe_d = 1'b0;
                irdy_oe_d  = 1'b0;
                busy_d     = 1'b0;
                st_d       = pmw_pkg::st_idle;
            end
            default: begin
                st_d = pmw_pkg::st_idle;
            end
        endcase
    end

    // Configuration cycle seen at start of another master's frame
    always_comb begin
        fprev_d = frame_n_i;
        cfg_d   = idsel && fprev_q && !frame_n_i && !frame_oe_q &&
                  ((cbe_n_i == `PMW_CMD_CFG_READ) || (cbe_n_i == `PMW_CMD_CFG_WRITE));
    end

    // ==========================================================
    // Registers, all on the rising edge
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q       <= pmw_pkg::st_idle;
            cmd_q      <= 4'h0;
            addr_q     <= `PMW_AD_RST;
            rem_q      <= '0;
            be_q       <= 4'h0;
            req_n_q    <= 1'b1;
            ad_q       <= `PMW_AD_RST;
            ad_oe_q    <= 1'b0;
            cbe_q      <= `PMW_CBE_RST;
            cbe_oe_q   <= 1'b0;
            frame_q    <= 1'b1;
            frame_oe_q <= 1'b0;
            irdy_q     <= 1'b1;
            irdy_oe_q  <= 1'b0;
            take_q     <= 1'b0;
            rdat_q     <= `PMW_AD_RST;
            rval_q     <= 1'b0;
            busy_q     <= 1'b0;
            done_q     <= 1'b0;
            cfg_q      <= 1'b0;
            fprev_q    <= 1'b1;
        end else begin
            st_q       <= st_d;
            cmd_q      <= cmd_d;
            addr_q     <= addr_d;
            rem_q      <= rem_d;
            be_q       <= be_d;
            req_n_q    <= req_n_d;
            ad_q       <= ad_d;
            ad_oe_q    <= ad_oe_d;
            cbe_q      <= cbe_d;
            cbe_oe_q   <= cbe_oe_d;
            frame_q    <= frame_d;
            frame_oe_q <= frame_oe_d;
            irdy_q     <= irdy_d;
            irdy_oe_q  <= irdy_oe_d;
            take_q     <= take_d;
            rdat_q     <= rdat_d;
            rval_q     <= rval_d;
            busy_q     <= busy_d;
            done_q     <= done_d;
            cfg_q      <= cfg_d;
            fprev_q    <= fprev_d;
        end
    end

    // Outputs straight from flops
    assign req_n      = req_n_q;
    assign ad_o       = ad_q;
    assign ad_oe      = ad_oe_q;
    assign cbe_n_o    = cbe_q;
    assign cbe_n_oe   = cbe_oe_q;
    assign frame_n_o  = frame_q;
    assign frame_n_oe = frame_oe_q;
    assign irdy_n_o   = irdy_q;
    assign irdy_n_oe  = irdy_oe_q;
    assign wr_take    = take_q;
    assign rd_data    = rdat_q;
    assign rd_valid   = rval_q;
    assign xfer_busy  = busy_q;
    assign xfer_done  = done_q;
    assign cfg_hit    = cfg_q;

    // ==========================================================
    // Wake event output
    pmw_wake_event #(
        .PULSE_CYC (PULSE_CYC)
    ) u_wake (
        .sys_clk              (sys_clk),
        .nrst                 (nrst),
        .wake_lan_enable      (wake_lan_enable),
        .wake_protocol_select (wake_protocol_select),
        .wake_frame           (wake_frame),
        .pm_event             (pm_event),
        .pme_clear            (pme_clear),
        .pme_n_o              (pme_n_o),
        .pme_n_oe             (pme_n_oe)
    );

    // ==========================================================
    // Assertions
    a_req_on_start: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_q == pmw_pkg::st_idle && xfer_start && xfer_len != '0) |=> !req_n ##1 1'b1)
        else $error("request not raised for transfer");
    a_req_until_gnt: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_q == pmw_pkg::st_req && gnt_n) |=> !req_n) else $error("request dropped before grant");
    a_frame_after_gnt: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(frame_n_oe) |-> $past(!gnt_n && frame_n_i && irdy_n_i)) else $error("frame without idle grant");
    a_frame_tenure: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_q == pmw_pkg::st_data && rem_q > LEN_W'(1)) |-> (frame_n_oe && !frame_n_o))
        else $error("frame released mid tenure");
    a_irdy_data: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_q == pmw_pkg::st_data) |-> (irdy_n_oe && !irdy_n_o)) else $error("irdy not asserted");
    a_addr_phase: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_q == pmw_pkg::st_addr) |-> (ad_oe && ad_o == addr_q)) else $error("address not driven");
    a_cmd_then_be: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_q == pmw_pkg::st_addr) |-> (cbe_n_o == cmd_q) ##1 (cbe_n_o == be_q && cbe_n_oe))
        else $error("command or byte enables wrong");
    a_reset_float: assert property (@(posedge sys_clk)
        !nrst |-> !(ad_oe || cbe_n_oe || frame_n_oe || irdy_n_oe || pme_n_oe) && req_n)
        else $error("output driven during reset");
    a_read_capture: assert property (@(posedge sys_clk) disable iff (!nrst)
        (st_q == pmw_pkg::st_data && !trdy_n && !is_write) |=> (rd_valid && rd_data == $past(ad_i)))
        else $error("read data not captured on edge");

    c_write_burst: cover property (@(posedge sys_clk) disable iff (!nrst)
        xfer_done && is_write && $past(st_q == pmw_pkg::st_data, 2));
    c_read_single: cover property (@(posedge sys_clk) disable iff (!nrst) rd_valid && xfer_done);
    c_cfg_seen: cover property (@(posedge sys_clk) disable iff (!nrst) cfg_hit);
endmodule

/* pmw_host_model.sv */
// Purpose: Host bridge, central arbiter and target model
// Assumes: Bench resolves the wire levels
// Notes:   wait_cyc sets target wait states
`timescale 1ns/1ps

module pmw_host_model (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        req_n,
    input  wire logic        irdy_w,
    input  wire logic [1:0]  wait_cyc,
    output logic             gnt_n,
    output logic             trdy_n,
    output logic [31:0]      host_ad
);
    logic [1:0]  wcnt_q;
    logic [7:0]  beat_q;
    logic [31:0] cyc_q;

    // ==========================================================
    // Arbiter and target, rising edge only
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            gnt_n  <= 1'b1;
            trdy_n <= 1'b1;
            wcnt_q <= 2'h0;
            beat_q <= 8'h00;
            cyc_q  <= 32'h0000_0000;
        end else begin
            gnt_n  <= req_n; // Grant only answers a pending request
            cyc_q  <= cyc_q + 32'h0000_0001;
            trdy_n <= !(!irdy_w && trdy_n && wcnt_q == wait_cyc);
            wcnt_q <= (!irdy_w && trdy_n && wcnt_q != wait_cyc) ? wcnt_q + 2'h1 : 2'h0;
            beat_q <= irdy_w ? 8'h00 : beat_q + {7'h00, !trdy_n};
        end
    end

    // Read word while ready, else a pattern that changes every cycle
    assign host_ad = !trdy_n ? {24'ha5a5a5, beat_q} : ~cyc_q;
endmodule

/* pmw_bus_master_tb_top.sv */
// Purpose: Self-checking bench for the bus master and wake block
// Assumes: Inputs driven on the falling edge
// Notes:   Wake pulse shortened to 8 cycles
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end

module pmw_bus_master_tb_top;
    logic        sys_clk = 0, nrst = 1, idsel = 0, tb_frame = 1, xfer_start = 0;
    logic [3:0]  tb_cbe = 4'hf, xfer_cmd = 4'h0, xfer_be_n = 4'hf, cbe_w, cbe_n_o;
    logic [31:0] xfer_addr = 32'h0, wr_data = 32'h1234_0000, ad_w, ad_o, rd_data, host_ad;
    logic [4:0]  xfer_len = 5'h0;
    logic [1:0]  wait_cyc = 2'h0;
    logic        wake_lan_enable = 0, wake_protocol_select = 0, wake_frame = 0;
    logic        pm_event = 0, pme_clear = 0, frame_w, irdy_w, frame_p = 1;
    logic        req_n, gnt_n, ad_oe, cbe_n_oe, frame_n_o, frame_n_oe, irdy_n_o, irdy_n_oe, trdy_n;
    logic        pme_n_o, pme_n_oe, wr_take, rd_valid, xfer_busy, xfer_done, cfg_hit;
    logic [31:0] aq[$], dq[$], rq[$];
    logic [3:0]  cq[$], bq[$];
    int          error_cnt = 0, samples_checked = 0;

    always #12.5 sys_clk = ~sys_clk;

    // Wire levels: strobes pulled up when nobody drives
    assign ad_w    = ad_oe ? ad_o : host_ad;
    assign cbe_w   = cbe_n_oe ? cbe_n_o : tb_cbe;
    assign frame_w = frame_n_oe ? frame_n_o : tb_frame;
    assign irdy_w  = irdy_n_oe ? irdy_n_o : 1'b1;

    pmw_bus_master #(.LEN_W(5), .PULSE_CYC(8)) pmw_bus_master_i (
        .sys_clk(sys_clk), .nrst(nrst), .req_n(req_n), .gnt_n(gnt_n), .idsel(idsel),
        .ad_i(ad_w), .ad_o(ad_o), .ad_oe(ad_oe), .cbe_n_i(cbe_w), .cbe_n_o(cbe_n_o),
        .cbe_n_oe(cbe_n_oe), .frame_n_i(frame_w), .frame_n_o(frame_n_o), .frame_n_oe(frame_n_oe),
        .irdy_n_i(irdy_w), .irdy_n_o(irdy_n_o), .irdy_n_oe(irdy_n_oe), .trdy_n(trdy_n),
        .pme_n_o(pme_n_o), .pme_n_oe(pme_n_oe), .xfer_start(xfer_start), .xfer_cmd(xfer_cmd),
        .xfer_addr(xfer_addr), .xfer_len(xfer_len), .xfer_be_n(xfer_be_n), .wr_data(wr_data),
        .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid), .xfer_busy(xfer_busy),
        .xfer_done(xfer_done), .cfg_hit(cfg_hit), .wake_lan_enable(wake_lan_enable),
        .wake_protocol_select(wake_protocol_select), .wake_frame(wake_frame),
        .pm_event(pm_event), .pme_clear(pme_clear));

    pmw_host_model pmw_host_model_i (
        .sys_clk(sys_clk), .nrst(nrst), .req_n(req_n), .irdy_w(irdy_w),
        .wait_cyc(wait_cyc), .gnt_n(gnt_n), .trdy_n(trdy_n), .host_ad(host_ad));

    // Bus monitor: address phases, data phases and read returns
    always @(posedge sys_clk) begin
        if (!frame_w && frame_p) begin
            aq.push_back(ad_w);
            cq.push_back(cbe_w);
        end
        frame_p = frame_w;
        if (!irdy_w && !trdy_n) begin
            dq.push_back(ad_w);
            bq.push_back(cbe_w);
        end
        if (rd_valid) rq.push_back(rd_data);
    end

    // Next write word after each take
    always @(negedge sys_clk) begin
        if (wr_take) wr_data <= wr_data + 32'h1111_1111;
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // One master transfer with address, command, data and byte-enable checks
    task automatic xfer(input logic [3:0] cmd, input logic [4:0] len, input logic [1:0] wt);
        int n = 0;
        int d = 0;
        logic [31:0] w0 = wr_data;
        aq.delete(); cq.delete(); dq.delete(); bq.delete(); rq.delete();
        wait_cyc = wt;
        xfer_cmd = cmd;
        xfer_addr = 32'h0040_0100 + {27'h0, len};
        xfer_be_n = 4'h3;
        xfer_len = len;
        xfer_start = 1;
        @(negedge sys_clk);
        xfer_start = 0;
        `CHK(req_n, 1'b0)
        while (xfer_busy !== 1'b0 && n < 80) begin
            @(negedge sys_clk);
            n++;
            if (xfer_done === 1'b1) d++;
        end
        `CHK(n < 80, 1'b1)
        `CHK(d, 1)
        `CHK(aq.size(), 1)
        `CHK(aq[0], xfer_addr)
        `CHK(cq[0], cmd)
        `CHK(dq.size(), int'(len))
        for (int i = 0; i < dq.size(); i++) begin
            `CHK(bq[i], 4'h3)
            if (cmd[0]) `CHK(dq[i], w0 + i * 32'h1111_1111)
            else `CHK(rq[i], {24'ha5a5a5, 8'(i)})
        end
        `CHK(frame_n_oe, 1'b0)
        $display("test xfer cmd %h len %0d done", cmd, len);
    endtask

    // Our frame must wait while another master owns the bus
    task automatic test_busy_bus();
        tb_frame = 0;
        @(negedge sys_clk); // Other master's address phase logged before ours starts
        fork
            xfer(4'h7, 5'h1, 2'h0);
            begin
                repeat (6) begin
                    @(negedge sys_clk);
                    `CHK(frame_n_oe, 1'b0)
                end
                tb_frame = 1;
            end
        join
    endtask

    // Configuration select with config and non-config commands
    task automatic test_cfg(input logic [3:0] cmd, input int exp);
        int c = 0;
        idsel = 1;
        tb_cbe = cmd;
        tb_frame = 0;
        repeat (4) begin
            @(negedge sys_clk);
            if (cfg_hit === 1'b1) c++;
        end
        tb_frame = 1;
        idsel = 0;
        tb_cbe = ~cmd;
        @(negedge sys_clk);
        `CHK(c, exp)
        $display("test cfg cmd %h done", cmd);
    endtask

    // Pulse one wake input and count cycles the wake line is pulled
    task automatic wake(input logic en, input logic sel, input logic frm, input int exp);
        int c = 0;
        wake_lan_enable = en;
        wake_protocol_select = sel;
        wake_frame = frm;
        pm_event = !frm;
        @(negedge sys_clk);
        wake_frame = 0;
        pm_event = 0;
        repeat (20) begin
            if (pme_n_oe === 1'b1) c++;
            @(negedge sys_clk);
        end
        `CHK(pme_n_o, 1'b0)
        `CHK(c, exp)
        pme_clear = 1;
        @(negedge sys_clk);
        pme_clear = 0;
        @(negedge sys_clk);
        `CHK(pme_n_oe, 1'b0)
        $display("test wake en %b sel %b done", en, sel);
    endtask

    // Main sequence
    initial begin
        #1 nrst = 0; // Real falling edge so every flop starts in reset
        repeat (2) @(negedge sys_clk);
        `CHK({ad_oe, cbe_n_oe, frame_n_oe, irdy_n_oe, pme_n_oe, req_n}, 6'h01)
        repeat (14) @(negedge sys_clk);
        nrst = 1;
        @(negedge sys_clk);
        xfer(4'h7, 5'h1, 2'h0);
        xfer(4'h7, 5'h3, 2'h2);
        xfer(4'h6, 5'h1, 2'h0);
        xfer(4'h6, 5'h4, 2'h1);
        test_busy_bus();
        test_cfg(4'ha, 1);
        test_cfg(4'hb, 1);
        test_cfg(4'h6, 0);
        wake(1'b0, 1'b1, 1'b1, 0);
        wake(1'b1, 1'b1, 1'b1, 8);
        wake(1'b1, 1'b0, 1'b1, 20);
        wake(1'b0, 1'b0, 1'b0, 20);
        finish_test();
    end

    // Watchdog over the expected run length
    initial begin
        #(25 * 4000);
        error_cnt++;
        finish_test();
    end
endmodule
